// ### core/lpsw_ladder_switch.sv
// Ladder power level control with automatic A/B interval switching.
//
// Decided for this implementation: the Avalon-MM register port and the placing of the registers.
`default_nettype none
`include "lpsw_map.svh"
//
// Function
// - Low, medium and high ladder power levels.
// - Ladder can be switched fully off.
// - Off ladder disconnects all taps.
// - Inactive module forces ladder off.
// - Setting A starts at each transition.
// - Setting B holds until next transition.
// - Three-bit duration; zero gives no A.
// - Five-bit prescaler times interval A.
// - A field 00 off, 01 low, 10 medium.
module lpsw_ladder_switch
    import lpsw_pkg::*;
#(
    parameter int PRE_WIDTH = `LPSW_PRE_WIDTH,
    parameter int PRE_DIV   = `LPSW_PRE_DIV
) (
    // Clock and reset
    input  wire logic        sys_clk,
    input  wire logic        rst,
    // Avalon-MM slave
    input  wire logic [3:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    // LCD timing, from pins of the LCD clock domain
    input  wire logic        lcd_active_flag,
    input  wire logic        lcd_clk_in,
    input  wire logic        lcd_transition,
    // Ladder control
    output logic [1:0]       ladder_level,
    output logic             ladder_connect,
    output logic             ladder_in_a
);
    initial begin
        if (PRE_WIDTH < 3 || PRE_WIDTH > 8 || PRE_DIV > (1 << PRE_WIDTH) || PRE_DIV < 8) begin
            $error("lpsw: unsupported prescaler parameters");
        end
    end

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        lpsw_ctrl_t     ctrl;
        logic [2:0]     act_sync;
        logic [2:0]     clk_sync;
        logic [2:0]     trn_sync;
        logic           active;
        logic           lclk;
        logic           trn;
        logic [7:0]     pre;
        logic           counting;
        lpsw_ladder_t   out;
        logic [31:0]    rdata;
        logic           wait_n;
    } lpsw_state_t;

    lpsw_state_t s_q;
    lpsw_state_t s_d;

    function automatic logic [1:0] decode_level(input logic [1:0] f);
        case (f)
            2'h0: decode_level = LPSW_OFF;
            2'h1: decode_level = LPSW_LOW;
            2'h2: decode_level = LPSW_MED;
            default: decode_level = LPSW_HIGH;
        endcase
    endfunction : decode_level

    function automatic logic agree(input logic [2:0] sy, input logic old);
        agree = (sy[1] == sy[2]) ? sy[2] : old;
    endfunction : agree

    logic       lclk_rise;
    logic       trn_rise;
    logic [7:0] pre_max;
    logic       sel_a;
    logic [1:0] lvl;

    always_comb begin
        s_d = s_q;
        pre_max = 8'(PRE_DIV - 1);
        s_d.act_sync = {s_q.act_sync[1:0], lcd_active_flag};
        s_d.clk_sync = {s_q.clk_sync[1:0], lcd_clk_in};
        s_d.trn_sync = {s_q.trn_sync[1:0], lcd_transition};
        s_d.active = agree(s_q.act_sync, s_q.active);
        s_d.lclk   = agree(s_q.clk_sync, s_q.lclk);
        s_d.trn    = agree(s_q.trn_sync, s_q.trn);
        lclk_rise = s_d.lclk & ~s_q.lclk;
        trn_rise  = s_d.trn & ~s_q.trn;
        // Prescaler count restarts at every segment or common change.
        if (trn_rise) begin
            s_d.pre = 8'h00;
            s_d.counting = 1'b1;
        end else if (lclk_rise && s_q.counting) begin
            if (s_q.pre == pre_max) begin
                s_d.counting = 1'b0;
            end else begin
                s_d.pre = s_q.pre + 8'h01;
            end
        end
        sel_a = s_q.counting && (s_q.pre < {5'h00, s_q.ctrl.dur_a});
        lvl = sel_a ? decode_level(s_q.ctrl.pwr_a) : decode_level(s_q.ctrl.pwr_b);
        if (!s_q.active) begin
            lvl = LPSW_OFF;
        end
        s_d.out.level   = lvl;
        s_d.out.connect = (lvl != LPSW_OFF);
        s_d.out.in_a    = sel_a & s_q.active;
        // Bus: every access answers one cycle after it is presented.
        s_d.wait_n = 1'b0;
        if ((avs_read || avs_write) && !s_q.wait_n) begin
            s_d.wait_n = 1'b1;
            s_d.rdata  = 32'h0000_0000;
            if (avs_write && avs_address == `LPSW_OFF_CTRL && avs_byteenable[0]) begin
                s_d.ctrl.pwr_a = avs_writedata[`LPSW_AP_HI:`LPSW_AP_LO];
                s_d.ctrl.pwr_b = avs_writedata[`LPSW_BP_HI:`LPSW_BP_LO];
                s_d.ctrl.dur_a = avs_writedata[`LPSW_AT_HI:`LPSW_AT_LO];
            end
            if (avs_read) begin
                case (avs_address)
                    `LPSW_OFF_CTRL: s_d.rdata[7:0] = {s_q.ctrl.pwr_a, s_q.ctrl.pwr_b,
                                                      1'b0, s_q.ctrl.dur_a};
                    `LPSW_OFF_STATUS: s_d.rdata[4:0] = {s_q.active, s_q.out.in_a,
                                                        s_q.out.connect, s_q.out.level};
                    `LPSW_OFF_TICK: s_d.rdata[7:0] = s_q.pre;
                    default: s_d.rdata = 32'h0000_0000;
                endcase
            end
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign avs_readdata    = s_q.rdata;
    assign avs_waitrequest = ~s_q.wait_n;
    assign ladder_level    = s_q.out.level;
    assign ladder_connect  = s_q.out.connect;
    assign ladder_in_a     = s_q.out.in_a;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    sequence seq_req; (avs_read || avs_write) && avs_waitrequest; endsequence

    chk_inactive_off: assert property (!s_q.active |=> ladder_level == 2'h0)
        else $error("ladder not off while inactive");
    chk_off_disconnect: assert property (ladder_level == 2'h0 |-> !ladder_connect)
        else $error("ladder connected while off");
    chk_on_connect: assert property (ladder_level != 2'h0 |-> ladder_connect)
        else $error("ladder disconnected while on");
    chk_zero_no_a: assert property (s_q.ctrl.dur_a == 3'h0 |=> !ladder_in_a)
        else $error("interval A with zero duration");
    chk_trn_restart: assert property (trn_rise |=> s_q.pre == 8'h00 && s_q.counting)
        else $error("prescaler not restarted");
    chk_a_level: assert property (s_q.active && sel_a |=> ladder_level ==
                                  decode_level($past(s_q.ctrl.pwr_a)))
        else $error("wrong level in interval A");
    chk_b_level: assert property (s_q.active && !sel_a |=> ladder_level ==
                                  decode_level($past(s_q.ctrl.pwr_b)))
        else $error("wrong level in interval B");
    chk_high_code: assert property (s_q.active && !sel_a && s_q.ctrl.pwr_b == 2'h3
                                    |=> ladder_level == 2'h3)
        else $error("code 11 not high");
    chk_low_code: assert property (s_q.active && sel_a && s_q.ctrl.pwr_a == 2'h1
                                   |=> ladder_level == 2'h1)
        else $error("code 01 not low");
    chk_med_code: assert property (s_q.active && sel_a && s_q.ctrl.pwr_a == 2'h2
                                   |=> ladder_level == 2'h2)
        else $error("code 10 not medium");
    chk_pre_bound: assert property (s_q.pre <= 8'(PRE_DIV - 1))
        else $error("prescaler past its limit");
    chk_bus_answer: assert property (seq_req |=> !avs_waitrequest)
        else $error("bus answer late");
endmodule : lpsw_ladder_switch
`default_nettype wire

// ### core/lpsw_map.svh
// Register offsets, field positions and timing counts of the ladder power switch.
`ifndef LPSW_MAP_SVH
`define LPSW_MAP_SVH
`define LPSW_OFF_CTRL    4'h0
`define LPSW_OFF_STATUS  4'h4
`define LPSW_OFF_TICK    4'h8
`define LPSW_CTRL_RESET  8'h00
`define LPSW_AP_HI       7
`define LPSW_AP_LO       6
`define LPSW_BP_HI       5
`define LPSW_BP_LO       4
`define LPSW_AT_HI       2
`define LPSW_AT_LO       0
`define LPSW_CTRL_MASK   8'hf7
`define LPSW_PRE_WIDTH   5
`define LPSW_PRE_DIV     32
`endif

// ### core/lpsw_pkg.sv
// Types shared by the ladder power switch.
`default_nettype none
package lpsw_pkg;
    typedef enum logic [1:0] {
        LPSW_OFF, LPSW_LOW, LPSW_MED, LPSW_HIGH
    } lpsw_level_t;
    typedef struct packed {
        logic [1:0] pwr_a;
        logic [1:0] pwr_b;
        logic [2:0] dur_a;
    } lpsw_ctrl_t;
    typedef struct packed {
        logic [1:0]  level;
        logic        connect;
        logic        in_a;
    } lpsw_ladder_t;
endpackage : lpsw_pkg
`default_nettype wire

// ### sim/lpsw_glass_model.sv
// LCD glass side: free-running LCD clock and segment transition pulses.
`default_nettype none
module lpsw_glass_model #(
    parameter int HALF = 16
) (
    // Clock and request
    input  wire logic sys_clk,
    input  wire logic go,
    // Glass lines
    output logic      lcd_clk_in,
    output logic      lcd_transition
);
    timeunit 1ns;
    timeprecision 1ps;
    int cnt = 0;
    initial lcd_clk_in = 1'b0;
    initial lcd_transition = 1'b0;
    // A transition starts on a falling clock edge, half a period before the next rise.
    always @(posedge sys_clk) begin
        cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
        if (cnt == HALF - 1) begin
            lcd_clk_in <= !lcd_clk_in;
            lcd_transition <= lcd_clk_in && go;
        end
    end
endmodule : lpsw_glass_model
`default_nettype wire

// ### sim/tb_lcd_ladder_power_switch.sv
// Self-checking bench for the ladder power switch.
`default_nettype none
module tb_lcd_ladder_power_switch import lpsw_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int HALF = 16;
    logic        sys_clk = 1'b0;
    logic        rst = 1'b1;
    logic [3:0]  avs_address = 4'h0;
    logic        avs_read = 1'b0;
    logic        avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata, rd;
    logic        avs_waitrequest, lcd_clk_in, lcd_transition, ladder_connect, ladder_in_a, ea;
    logic        lcd_active_flag = 1'b0;
    logic        go = 1'b0;
    logic [1:0]  ladder_level, pa, pb;
    logic [2:0]  du;
    int          miscompares = 0;
    int          checks = 0;
    int          cyc = 0;
    integer      seed = 32'h6fd8;
    lpsw_ladder_switch u_lpsw_ladder_switch (
        .sys_clk(sys_clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'h1),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .lcd_active_flag(lcd_active_flag), .lcd_clk_in(lcd_clk_in),
        .lcd_transition(lcd_transition), .ladder_level(ladder_level),
        .ladder_connect(ladder_connect), .ladder_in_a(ladder_in_a));
    lpsw_glass_model #(.HALF(HALF)) u_lpsw_glass_model (
        .sys_clk(sys_clk), .go(go), .lcd_clk_in(lcd_clk_in), .lcd_transition(lcd_transition));
    initial forever #12.5 sys_clk = ~sys_clk;
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc > 20000) begin
            miscompares++;
            final_report;
        end
    end
    task automatic bus(input logic we, input logic [3:0] a, input logic [7:0] wd,
                       output logic [31:0] rdat);
        avs_address <= a;
        avs_write <= we;
        avs_read <= !we;
        avs_writedata <= {24'h0, wd};
        do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
        rdat = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        @(posedge sys_clk);
    endtask : bus
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic fire;
        go <= 1'b1;
        do @(posedge sys_clk); while (lcd_transition !== 1'b1);
        go <= 1'b0;
    endtask : fire
    function automatic logic [1:0] lvl(input logic sel_a, input logic [1:0] a, input logic [1:0] b);
        return sel_a ? a : b;
    endfunction : lvl
    task automatic final_report;
        $display("checks=%0d miscompares=%0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : final_report
    initial begin
        repeat (10) @(posedge sys_clk);
        rst <= 1'b0;
        @(posedge sys_clk);
        bus(0, 4'h0, 8'h0, rd);
        chk(rd, 32'h0);
        bus(1, 4'h0, 8'hff, rd);
        bus(0, 4'h0, 8'h0, rd);
        chk(rd, 32'hf7);
        bus(0, 4'hc, 8'h0, rd);
        chk(rd, 32'h0);
        fire;
        repeat (HALF) @(posedge sys_clk);
        chk({ladder_level, ladder_connect}, 3'h0);
        lcd_active_flag <= 1'b1;
        // Every A and B code first, then random settings; a zero duration is forced once.
        for (int i = 0; i < 12; i++) begin
            pa = (i < 4) ? i[1:0] : 2'($random(seed));
            pb = (i < 4) ? 2'(3 - i) : 2'($random(seed));
            du = (i == 4) ? 3'h0 : 3'($random(seed));
            bus(1, 4'h0, {pa, pb, 1'b0, du}, rd);
            fire;
            repeat (HALF - 6) @(posedge sys_clk);
            ea = (du != 3'h0);
            chk({ladder_in_a, ladder_level, ladder_connect},
                {ea, lvl(ea, pa, pb), lvl(ea, pa, pb) != 2'h0});
            repeat (2 * HALF * du + HALF) @(posedge sys_clk);
            bus(0, 4'h4, 8'h0, rd);
            chk(rd, {27'h0, 1'b1, 1'b0, pb != 2'h0, pb});
        end
        final_report;
    end
endmodule : tb_lcd_ladder_power_switch
`default_nettype wire
